//--- design/isx_addr_unit.v
`timescale 1ns/10ps
// ============================================================
// address and pointer update calculator
`include "isx_regs.vh"
module isx_addr_unit
#(
  parameter AW = 16
)
(
  input  wire [AW-1:0] ptr,
  input  wire          rel_form,
  input  wire [1:0]    mode,
  input  wire [5:0]    k_off,
  output reg  [AW-1:0] eff_addr,
  output reg  [AW-1:0] ptr_next
);
  wire [AW-1:0] ptr_inc;
  wire [AW-1:0] ptr_dec;
  wire [AW-1:0] k_ext;

  // modular arithmetic; carry out dropped so the pointer wraps
  assign ptr_inc = ptr + `ISX_ONE;
  assign ptr_dec = ptr - `ISX_ONE;
  // k sign-extended, spans -32..31
  assign k_ext   = {{(AW-6){k_off[5]}}, k_off};

  // pick effective address and the pointer written back
  always @*
  begin
    eff_addr = ptr;
    ptr_next = ptr;
    if (rel_form)
    begin
      eff_addr = ptr + k_ext;
      ptr_next = ptr;
    end
    else
    begin
      case (mode)
        `ISX_MM_PREINC:
        begin
          eff_addr = ptr_inc;
          ptr_next = ptr_inc;
        end
        `ISX_MM_PREDEC:
        begin
          eff_addr = ptr_dec;
          ptr_next = ptr_dec;
        end
        `ISX_MM_POSTINC:
        begin
          eff_addr = ptr;
          ptr_next = ptr_inc;
        end
        `ISX_MM_POSTDEC:
        begin
          eff_addr = ptr;
          ptr_next = ptr_dec;
        end
        default:
        begin
          eff_addr = ptr;
          ptr_next = ptr;
        end
      endcase
    end
  end
endmodule // isx_addr_unit

//--- design/isx_exec.v
`timescale 1ns/10ps
`include "isx_regs.vh"
module isx_exec
#(
  parameter AW = 16,
  parameter DW = 8
)
(
  input  wire          mclk,
  input  wire          rst_b,
  input  wire          ce,
  input  wire          instr_valid,
  input  wire [2:0]    op,
  input  wire          ptr_sel,
  input  wire [1:0]    mode,
  input  wire [5:0]    k_off,
  input  wire [DW-1:0] w_in,
  input  wire          ptr_wr,
  input  wire          ptr_wr_sel,
  input  wire [AW-1:0] ptr_wr_data,
  input  wire          ri_flag_set,
  input  wire [DW-1:0] status_in,
  output reg  [AW-1:0] file_select_pointer0_q,
  output reg  [AW-1:0] file_select_pointer1_q,
  output reg           mem_we_q,
  output reg  [AW-1:0] mem_addr_q,
  output reg  [DW-1:0] mem_wdata_q,
  output reg  [DW-1:0] presc_cfg_q,
  output reg           pc_inc_q,
  output reg           sw_reset_q,
  output reg           reset_instruction_flag_n_q,
  output reg  [DW-1:0] status_out_q,
  output reg  [DW-1:0] w_out_q
);
  // ============================================================
  // output timing
  // an instruction is taken at a rising edge with ce and instr_valid high
  // and its effect shows on the outputs one cycle later
  // mem_we_q, pc_inc_q and sw_reset_q are single-cycle pulses
  // mem_addr_q and mem_wdata_q hold their value until the next store
  // presc_cfg_q holds until an instruction changes it, the pointers until a store or a ptr_wr write changes them
  // w_out_q and status_out_q are plain copies of w_in and status_in
  // ce low freezes every register, the pulses included, so the core
  // must not count a pulse twice while it holds ce low
  // sw_reset_q is a request only: the device reset system answers it
  // by pulling rst_b low, and rst_b leaves the cause flag alone
  // the cause flag has no power-up value of its own; power-on logic
  // must raise ri_flag_set once before software reads it
  // opcodes outside the decoded set only advance the program counter

  // ============================================================
  // decode and pointer select
  wire          is_upd;
  wire          is_rel;
  wire          is_store;
  wire          go;
  wire [AW-1:0] sel_ptr;
  wire [AW-1:0] eff_addr;
  wire [AW-1:0] ptr_next;
  wire          is_presc;
  wire          is_swrst;
  reg  [AW-1:0] file_select_pointer0_d;
  reg  [AW-1:0] file_select_pointer1_d;
  reg  [DW-1:0] presc_cfg_d;
  reg           reset_instruction_flag_n_d;

  // every opcode decode goes through one function
  function is_op;
    input [2:0] code;
    input [2:0] want;
    begin
      is_op = (code == want);
    end
  endfunction

  assign go       = ce & instr_valid;
  assign is_upd   = is_op(op, `ISX_OP_STORE_UPD);
  assign is_rel   = is_op(op, `ISX_OP_STORE_REL);
  assign is_store = is_upd | is_rel;
  // single-slot register instructions
  assign is_presc = is_op(op, `ISX_OP_LOAD_PRESC);
  assign is_swrst = is_op(op, `ISX_OP_SW_RESET);
  // the window has no storage; pointer chosen by the instruction
  assign sel_ptr  = ptr_sel ? file_select_pointer1_q : file_select_pointer0_q;

  isx_addr_unit #(.AW(AW)) u_addr
  (
    .ptr      (sel_ptr),
    .rel_form (is_rel),
    .mode     (mode),
    .k_off    (k_off),
    .eff_addr (eff_addr),
    .ptr_next (ptr_next)
  );

  // ============================================================
  // pointer next values
  // a store owns the slot: a plain pointer write there is dropped,
  // because merging the two would lose the store's update
  // and software would see a pointer it never asked for
  always @*
  begin
    file_select_pointer0_d = file_select_pointer0_q;
    file_select_pointer1_d = file_select_pointer1_q;
    if (go && is_store)
    begin
      if (ptr_sel)
        file_select_pointer1_d = ptr_next;
      else
        file_select_pointer0_d = ptr_next;
    end
    else if (ptr_wr)
    begin
      if (ptr_wr_sel)
        file_select_pointer1_d = ptr_wr_data;
      else
        file_select_pointer0_d = ptr_wr_data;
    end
  end

  // ============================================================
  // pointers and data memory write port
  always @(posedge mclk)
  begin
    if (!rst_b)
    begin
      file_select_pointer0_q <= `ISX_PTR_RST;
      file_select_pointer1_q <= `ISX_PTR_RST;
      mem_we_q               <= 1'b0;
      mem_addr_q             <= `ISX_PTR_RST;
      mem_wdata_q            <= `ISX_DATA_RST;
    end
    else if (ce)
    begin
      mem_we_q               <= go & is_store;
      file_select_pointer0_q <= file_select_pointer0_d;
      file_select_pointer1_q <= file_select_pointer1_d;
      if (go && is_store)
      begin
        mem_addr_q  <= eff_addr;
        mem_wdata_q <= w_in;
      end
    end
  end

  // ============================================================
  // prescaler load, working register and status pass-through
  always @*
  begin
    presc_cfg_d = presc_cfg_q;
    if (go && is_presc)
      presc_cfg_d = w_in;
  end

  // w and status are copied only, never computed on, so the
  // core sees them unchanged one slot later
  always @(posedge mclk)
  begin
    if (!rst_b)
    begin
      presc_cfg_q  <= `ISX_PRESC_RST;
      w_out_q      <= `ISX_DATA_RST;
      status_out_q <= `ISX_DATA_RST;
      pc_inc_q     <= 1'b0;
    end
    else if (ce)
    begin
      presc_cfg_q  <= presc_cfg_d;
      // w and flags are never modified by these instructions
      w_out_q      <= w_in;
      status_out_q <= status_in;
      // every instruction here except the software reset, nop included, is a one-slot step
      pc_inc_q     <= go & ~is_op(op, `ISX_OP_SW_RESET);
    end
  end

  // ============================================================
  // software reset and its cause flag
  // the flag survives rst_b so software can read the cause after a
  // software reset; power-on logic restores it through ri_flag_set
  always @(posedge mclk)
  begin
    if (!rst_b)
    begin
      sw_reset_q <= 1'b0;
    end
    else if (ce)
    begin
      sw_reset_q <= go & is_swrst;
    end
  end

  // next cause flag: the reset instruction's clear wins over a set in
  // the same slot, so a racing power-on write cannot hide the cause
  always @*
  begin
    reset_instruction_flag_n_d = reset_instruction_flag_n_q;
    if (go && is_swrst)
      reset_instruction_flag_n_d = 1'b0;
    else if (ri_flag_set)
      reset_instruction_flag_n_d = 1'b1;
  end

  // flag register; no rst_b branch so the cause survives the reset
  always @(posedge mclk)
  begin
    if (ce)
      reset_instruction_flag_n_q <= reset_instruction_flag_n_d;
  end
endmodule // isx_exec

//--- design/isx_regs.vh
`ifndef ISX_REGS_VH
`define ISX_REGS_VH
// ============================================================
// instruction codes presented on the op input
`define ISX_OP_NOP        3'h0
`define ISX_OP_STORE_UPD  3'h1
`define ISX_OP_STORE_REL  3'h2
`define ISX_OP_LOAD_PRESC 3'h3
`define ISX_OP_SW_RESET   3'h4
// ============================================================
// pointer update mode codes
`define ISX_MM_PREINC     2'h0
`define ISX_MM_PREDEC     2'h1
`define ISX_MM_POSTINC    2'h2
`define ISX_MM_POSTDEC    2'h3
// ============================================================
// reset values and offset limits
`define ISX_PTR_RST       16'h0000
`define ISX_PRESC_RST     8'hff
`define ISX_DATA_RST      8'h00
`define ISX_K_MIN         6'h20
`define ISX_K_MAX         6'h1f
`define ISX_ONE           16'h0001
`endif

//--- dv/isx_exec_sva.sv
`timescale 1ns/10ps
// ====
// checker on the execution unit ports
module isx_exec_chk
(
  input wire        mclk,
  input wire        rst_b,
  input wire        ce,
  input wire        instr_valid,
  input wire [2:0]  op,
  input wire        ptr_sel,
  input wire [1:0]  mode,
  input wire [5:0]  k_off,
  input wire [7:0]  w_in,
  input wire [7:0]  status_in,
  input wire [15:0] file_select_pointer0_q,
  input wire        mem_we_q,
  input wire [15:0] mem_addr_q,
  input wire [7:0]  mem_wdata_q,
  input wire [7:0]  presc_cfg_q,
  input wire        pc_inc_q,
  input wire        sw_reset_q,
  input wire        reset_instruction_flag_n_q,
  input wire [7:0]  status_out_q
);
  // accepted instruction; pointer 0 cases only, to keep the checks short
  wire        go = ce & instr_valid & ~ptr_sel;
  wire [15:0] p0 = file_select_pointer0_q;
  default clocking @(posedge mclk); endclocking
  default disable iff (!rst_b);
  chk_store_copy: assert property (go && op inside {1, 2} |=>
    mem_we_q && mem_wdata_q == $past(w_in)) else $error("store data wrong");
  chk_preinc_addr: assert property (go && op == 1 && mode == 0 |=>
    mem_addr_q == $past(p0) + 16'h1) else $error("preinc address wrong");
  chk_postdec_ptr: assert property (go && op == 1 && mode == 3 |=>
    p0 == $past(p0) - 16'h1 && mem_addr_q == $past(p0)) else $error("postdec wrong");
  chk_rel_addr: assert property (go && op == 2 |=> $stable(p0) &&
    mem_addr_q == $past(p0) + {{10{$past(k_off[5])}}, $past(k_off)}) else $error("rel wrong");
  chk_presc_load: assert property (ce && instr_valid && op == 3 |=>
    presc_cfg_q == $past(w_in)) else $error("prescaler load wrong");
  chk_sw_reset: assert property (ce && instr_valid && op == 4 |=>
    sw_reset_q && !reset_instruction_flag_n_q) else $error("software reset wrong");
  chk_status_kept: assert property (rst_b && ce |=>
    status_out_q == $past(status_in)) else $error("status changed");
  chk_nop_quiet: assert property (ce && instr_valid && op == 0 |=>
    pc_inc_q && !mem_we_q && !sw_reset_q && $stable(presc_cfg_q)) else $error("nop acted");
endmodule // isx_exec_chk
bind isx_exec isx_exec_chk i_isx_exec_chk
(
  .mclk(mclk), .rst_b(rst_b), .ce(ce), .instr_valid(instr_valid), .op(op),
  .ptr_sel(ptr_sel), .mode(mode), .k_off(k_off), .w_in(w_in), .status_in(status_in),
  .file_select_pointer0_q(file_select_pointer0_q), .mem_we_q(mem_we_q),
  .mem_addr_q(mem_addr_q), .mem_wdata_q(mem_wdata_q), .presc_cfg_q(presc_cfg_q),
  .pc_inc_q(pc_inc_q), .sw_reset_q(sw_reset_q),
  .reset_instruction_flag_n_q(reset_instruction_flag_n_q), .status_out_q(status_out_q)
);

//--- dv/tb_isx_exec.sv
`timescale 1ns/10ps
`include "isx_regs.vh"
module tb_isx_exec;
  logic        mclk, rst_b, ce, instr_valid, ptr_sel, ptr_wr, ptr_wr_sel, ri_flag_set;
  logic [2:0]  op;
  logic [1:0]  mode;
  logic [5:0]  k_off;
  logic [7:0]  w_in, status_in, presc_cfg_q, w_out_q, status_out_q, mem_wdata_q;
  logic [15:0] file_select_pointer0_q, file_select_pointer1_q, ptr_wr_data, mem_addr_q;
  logic        mem_we_q, pc_inc_q, sw_reset_q, reset_instruction_flag_n_q;
  int          miscompares, checks_done;
  isx_exec i_isx_exec
  (
    .mclk(mclk), .rst_b(rst_b), .ce(ce), .instr_valid(instr_valid), .op(op),
    .ptr_sel(ptr_sel), .mode(mode), .k_off(k_off), .w_in(w_in), .ptr_wr(ptr_wr),
    .ptr_wr_sel(ptr_wr_sel), .ptr_wr_data(ptr_wr_data), .ri_flag_set(ri_flag_set),
    .status_in(status_in), .file_select_pointer0_q(file_select_pointer0_q),
    .file_select_pointer1_q(file_select_pointer1_q), .mem_we_q(mem_we_q),
    .mem_addr_q(mem_addr_q), .mem_wdata_q(mem_wdata_q), .presc_cfg_q(presc_cfg_q),
    .pc_inc_q(pc_inc_q), .sw_reset_q(sw_reset_q),
    .reset_instruction_flag_n_q(reset_instruction_flag_n_q),
    .status_out_q(status_out_q), .w_out_q(w_out_q)
  );
  // ====
  // shared helpers
  task automatic chk(input logic [15:0] seen, exp, input string what);
    checks_done++;
    if (seen !== exp)
    begin
      miscompares++;
      $display("BAD %s exp %h seen %h", what, exp, seen);
    end
  endtask
  task automatic wrap_up;
    if (miscompares == 0 && checks_done > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask
  // one instruction: op, pointer select, mode, offset; outputs settle 1ns after
  task automatic issue(input logic [11:0] f);
    @(posedge mclk);
    {op, ptr_sel, mode, k_off, instr_valid} <= {f, 1'b1};
    @(posedge mclk);
    instr_valid <= 1'b0;
    #1;
  endtask
  task automatic setp(input logic s, input logic [15:0] v);
    @(posedge mclk);
    {ptr_wr, ptr_wr_sel, ptr_wr_data} <= {1'b1, s, v};
    @(posedge mclk);
    ptr_wr <= 1'b0;
  endtask
  // ====
  // scenarios
  task automatic t_presc;
    chk(presc_cfg_q, 16'h00ff, "presc rst");
    @(posedge mclk) w_in <= 8'h4f;
    issue({`ISX_OP_LOAD_PRESC, 9'h000});
    chk(presc_cfg_q, 16'h004f, "presc");
    chk(w_out_q, 16'h004f, "w kept");
  endtask
  task automatic t_nop;
    issue({`ISX_OP_NOP, 9'h000});
    chk(pc_inc_q, 1, "pc inc");
    chk(mem_we_q, 0, "nop we");
  endtask
  // every mode, started at the edge of the range so each one wraps
  task automatic t_modes;
    logic [15:0] b, d;
    logic        s;
    for (int m = 0; m < 4; m++)
    begin
      b = m[0] ? 16'h0000 : 16'hffff;
      d = m[0] ? 16'hffff : 16'h0001;
      s = m[0] ^ m[1];
      setp(s, b);
      {w_in, status_in} <= {6'h28, m[1:0], 6'h0c, m[1:0]};
      issue({`ISX_OP_STORE_UPD, s, m[1:0], 6'h00});
      chk(mem_we_q, 1, "we");
      chk(mem_wdata_q, {8'h00, w_in}, "wdata");
      chk(mem_addr_q, m[1] ? b : b + d, "addr");
      chk(s ? file_select_pointer1_q : file_select_pointer0_q, b + d, "ptr");
      chk(status_out_q, {8'h00, status_in}, "status");
    end
  endtask
  task automatic t_rel;
    setp(1'b0, 16'h0010);
    issue({`ISX_OP_STORE_REL, 3'h0, 6'h20});
    chk(mem_addr_q, 16'hfff0, "rel lo");
    chk(file_select_pointer0_q, 16'h0010, "rel ptr");
    issue({`ISX_OP_STORE_REL, 3'h0, 6'h1f});
    chk(mem_addr_q, 16'h002f, "rel hi");
  endtask
  task automatic t_swrst;
    @(posedge mclk) ri_flag_set <= 1'b1;
    @(posedge mclk) ri_flag_set <= 1'b0;
    #1;
    chk(reset_instruction_flag_n_q, 1, "flag set");
    issue({`ISX_OP_SW_RESET, 9'h000});
    chk(sw_reset_q, 1, "swr");
    chk(pc_inc_q, 0, "swr pc");
    chk(reset_instruction_flag_n_q, 0, "flag");
    // the reset system answers the request; the cause must survive it
    @(posedge mclk) rst_b <= 1'b0;
    @(posedge mclk) rst_b <= 1'b1;
    #1;
    chk(reset_instruction_flag_n_q, 0, "flag kept");
    chk(presc_cfg_q, 16'h00ff, "presc after rst");
  endtask
  // ====
  // clock, watchdog and main sequence
  initial
  begin
    mclk = 1'b0;
    forever #20 mclk = ~mclk;
  end
  initial
  begin
    repeat (500) @(posedge mclk);
    miscompares++;
    wrap_up;
  end
  initial
  begin
    {rst_b, instr_valid, op, ptr_sel, mode, k_off, ptr_wr, ptr_wr_sel, ptr_wr_data} = '0;
    ri_flag_set = 1'b0;
    ce = 1'b1;
    w_in = 8'h5a;
    status_in = 8'hc3;
    repeat (12) @(posedge mclk);
    rst_b <= 1'b1;
    t_presc;
    t_nop;
    t_modes;
    t_rel;
    t_swrst;
    wrap_up;
  end
endmodule // tb_isx_exec
